// ===== common/dbs_cfg.svh
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH
// ==========================================
// Special-function addresses
`define DBS_ADDR_UNBANKED_WIN 8'h00
`define DBS_ADDR_BANK0_PTR 8'h01
`define DBS_ADDR_BANKED_WIN 8'h02
`define DBS_ADDR_PTR_FIRST 8'h03
`define DBS_ADDR_BSEL_FIRST 8'h04
`define DBS_ADDR_ACC 8'h05
`define DBS_ADDR_PCL 8'h06
`define DBS_ADDR_TBL_LOW 8'h07
`define DBS_ADDR_TBL_HIGH_LATCH 8'h08
`define DBS_ADDR_WDT_SEL 8'h09
`define DBS_ADDR_STATUS 8'h0a
`define DBS_ADDR_DAC_CTRL 8'h1f
`define DBS_ADDR_TBL_MID 8'h2b
`define DBS_ADDR_TBL_HIGH 8'h2c
`define DBS_ADDR_PTR_SECOND 8'h2e
`define DBS_ADDR_BSEL_SECOND 8'h2f
`define DBS_ADDR_GP_START 8'h60
// ==========================================
// Field positions and masks
`define DBS_BSEL_MASK 8'h1f
`define DBS_WDT_SEL_MASK 8'h07
`define DBS_PTR_CHOICE_BIT 7
`define DBS_ST_C 0
`define DBS_ST_AC 1
`define DBS_ST_Z 2
`define DBS_ST_OV 3
`define DBS_ST_PDF 4
`define DBS_ST_TO 5
`define DBS_ST_ARITH_MASK 8'h0f
// ==========================================
// Reset values
`define DBS_BSEL_RST 8'h00
`define DBS_BYTE_RST 8'h00
`define DBS_WDT_SEL_RST 8'h07
// ==========================================
// Watchdog timing: base count before division
`define DBS_WDT_BASE_CYCLES 16'h0100
`endif

// ===== common/dbs_pkg.sv
package dbs_pkg;
  // ==========================================
  // Data memory access request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dbs_mem_req_type;
  // ALU flag update request
  typedef struct packed {
    logic upd_arith;
    logic upd_c_only;
    logic c;
    logic ac;
    logic z;
    logic ov;
  } dbs_flag_upd_type;
  // Physical memory port: 11-bit address
  typedef struct packed {
    logic rd;
    logic wr;
    logic [10:0] addr;
    logic [7:0] wdata;
  } dbs_ram_req_type;
  typedef enum logic [1:0] {
    DBS_EX_RUN = 2'b00,
    DBS_EX_IDLE = 2'b01
  } dbs_ex_state_type;
endpackage : dbs_pkg

// ===== src/dbs_watchdog.sv
`timescale 1ns/1ps
`include "dbs_cfg.svh"
// ==========================================
// Watchdog prescaler and counter
module dbs_watchdog (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_kick,
  input wire logic [2:0] i_div_sel,
  output logic o_timeout
);
  logic [6:0] div_q;
  logic [15:0] cnt_q;
  logic tick;

  // Division ratio 1..128 picked by three bits
  always_comb begin
    tick = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(i_div_sel)) begin
        tick = tick & div_q[i];
      end
    end
  end

  // Prescaler
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 7'h00;
    end else if (i_ce) begin
      div_q <= i_kick ? 7'h00 : div_q + 7'h01;
    end
  end

  // Counter raises a one-cycle overflow pulse
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 16'h0000;
      o_timeout <= 1'b0;
    end else if (i_ce) begin
      o_timeout <= 1'b0;
      if (i_kick) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        if (cnt_q == `DBS_WDT_BASE_CYCLES - 16'h0001) begin
          cnt_q <= 16'h0000;
          o_timeout <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule : dbs_watchdog

// ===== src/dbs_core_regs.sv
`timescale 1ns/1ps
`include "dbs_cfg.svh"
// Operation
// - Bank-select bits 0..2 hold a binary bank number, banks zero to seven.
// - Bank-select bits 3..4 are plain storage; bits 5..7 unused.
// - First bank select pairs with first pointer, second with second.
// - Converter control bit 7 picks second banked pointer when set.
// - Unbanked window always reaches bank zero at its pointer address.
// - Resets clear bank selection except watchdog time-out during power-down.
// - Special-function addresses are never redirected by bank selection.
// - Direct data memory accesses always go to bank zero.
// - Program-counter low writes jump within the current page only.
// - Program-counter low write inserts one idle instruction cycle.
// - Table read puts high byte in latch, low byte at destination.
// - Watchdog select uses low three bits, ratio 1..128; overflow resets.
// - Status writes change arithmetic flags only, not expiry or sleep flags.
// - Carry set on add carry or subtract no-borrow; rotate updates it.
// - Nibble carry set on low-nibble carry or no nibble borrow.
// - Zero flag follows whether the result equals zero.
// - Overflow set when carry into top bit differs from carry out.
// - Sleep flag cleared by power-up or kick, set by sleep instruction.
// - Expiry flag cleared by power-up, kick or sleep; set by time-out.
// - Interrupts and calls never push status automatically.
// - All results pass through the accumulator; no memory-to-memory copy.
// - Indirect access to a window location reads zero, writes nothing.
// - Unused special-function addresses read zero.
module dbs_core_regs
  import dbs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_power_up,
  input wire logic i_sleep_op,
  input wire logic i_kick_op,
  input wire logic i_indirect,
  input dbs_pkg::dbs_mem_req_type i_req,
  input wire logic [7:0] i_ram_rdata,
  input dbs_pkg::dbs_flag_upd_type i_flags,
  input wire logic i_tbl_done,
  input wire logic [15:0] i_tbl_word,
  input wire logic [7:0] i_alu_result,
  input wire logic i_alu_wr_acc,
  output dbs_pkg::dbs_ram_req_type o_ram,
  output logic [7:0] o_rdata,
  output logic [7:0] o_acc,
  output logic o_pcl_load,
  output logic [7:0] o_pcl_value,
  output logic o_stall,
  output logic [23:0] o_tbl_addr,
  output logic [7:0] o_tbl_low,
  output logic o_tbl_low_valid,
  output logic o_wdt_reset,
  output logic [7:0] o_status,
  output logic o_sleeping
);
  logic [7:0] bsel1_q, bsel2_q, ptr0_q, ptr1_q, ptr2_q, acc_q, dacc_q;
  logic [7:0] tblp_q, tbmp_q, tbhp_q, table_high_latch_q, watchdog_divider_select_q, pcl_q;
  logic c_q, ac_q, z_q, ov_q, pdf_q, to_q;
  logic sleep_q, idle_q;
  dbs_ex_state_type ex_q;
  logic wdt_to;
  logic [7:0] eff_addr, sfr_rd;
  logic [2:0] eff_bank;
  logic is_sfr, wr_ok, rd_ok, win_hit;
  logic fl_c, fl_ac, fl_z, fl_ov;

  // ==========================================
  // Address formation
  always_comb begin
    eff_addr = i_req.addr;
    eff_bank = 3'h0;
    win_hit = 1'b0;
    if (i_indirect) begin
      if (i_req.addr == `DBS_ADDR_UNBANKED_WIN) begin
        eff_addr = ptr0_q;
        eff_bank = 3'h0;
      end else if (i_req.addr == `DBS_ADDR_BANKED_WIN) begin
        if (dacc_q[`DBS_PTR_CHOICE_BIT]) begin
          eff_addr = ptr2_q;
          eff_bank = bsel2_q[2:0];
        end else begin
          eff_addr = ptr1_q;
          eff_bank = bsel1_q[2:0];
        end
      end
      win_hit = (eff_addr == `DBS_ADDR_UNBANKED_WIN) ||
                (eff_addr == `DBS_ADDR_BANKED_WIN);
    end
    is_sfr = eff_addr < `DBS_ADDR_GP_START;
    wr_ok = i_req.wr && !win_hit && !idle_q && !sleep_q;
    rd_ok = i_req.rd && !win_hit;
  end

  // Register write strobe for one address
  function automatic logic sfr_we(input logic [7:0] a, input logic [7:0] ea,
                                  input logic ok, input logic sfr);
    sfr_we = ok && sfr && (ea == a);
  endfunction : sfr_we

  // ==========================================
  // Special-function read mux
  always_comb begin
    unique case (eff_addr)
      `DBS_ADDR_BANK0_PTR: sfr_rd = ptr0_q;
      `DBS_ADDR_PTR_FIRST: sfr_rd = ptr1_q;
      `DBS_ADDR_BSEL_FIRST: sfr_rd = bsel1_q & `DBS_BSEL_MASK;
      `DBS_ADDR_ACC: sfr_rd = acc_q;
      `DBS_ADDR_PCL: sfr_rd = pcl_q;
      `DBS_ADDR_TBL_LOW: sfr_rd = tblp_q;
      `DBS_ADDR_TBL_HIGH_LATCH: sfr_rd = table_high_latch_q;
      `DBS_ADDR_WDT_SEL: sfr_rd = watchdog_divider_select_q & `DBS_WDT_SEL_MASK;
      `DBS_ADDR_STATUS: sfr_rd = {2'h0, to_q, pdf_q, ov_q, z_q, ac_q, c_q};
      `DBS_ADDR_DAC_CTRL: sfr_rd = dacc_q;
      `DBS_ADDR_TBL_MID: sfr_rd = tbmp_q;
      `DBS_ADDR_TBL_HIGH: sfr_rd = tbhp_q;
      `DBS_ADDR_PTR_SECOND: sfr_rd = ptr2_q;
      `DBS_ADDR_BSEL_SECOND: sfr_rd = bsel2_q & `DBS_BSEL_MASK;
      default: sfr_rd = 8'h00;
    endcase
  end

  // ==========================================
  // Memory port and read data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ram <= '0;
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_ram.rd <= rd_ok && !is_sfr;
      o_ram.wr <= wr_ok && !is_sfr;
      o_ram.addr <= {eff_bank, eff_addr};
      o_ram.wdata <= i_req.wdata;
      // RAM answers last cycle's address; core leaves a free cycle behind a RAM read
      if (o_ram.rd) begin
        o_rdata <= i_ram_rdata;
      end else if (!rd_ok) begin
        o_rdata <= 8'h00;
      end else if (is_sfr) begin
        o_rdata <= sfr_rd;
      end
    end
  end

  // ==========================================
  // Bank selects; watchdog reset in power-down keeps them
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bsel1_q <= `DBS_BSEL_RST;
      bsel2_q <= `DBS_BSEL_RST;
    end else if (i_ce) begin
      if (i_power_up || (wdt_to && !sleep_q)) begin
        bsel1_q <= `DBS_BSEL_RST;
        bsel2_q <= `DBS_BSEL_RST;
      end else begin
        if (sfr_we(`DBS_ADDR_BSEL_FIRST, eff_addr, wr_ok, is_sfr)) begin
          bsel1_q <= i_req.wdata & `DBS_BSEL_MASK;
        end
        if (sfr_we(`DBS_ADDR_BSEL_SECOND, eff_addr, wr_ok, is_sfr)) begin
          bsel2_q <= i_req.wdata & `DBS_BSEL_MASK;
        end
      end
    end
  end

  // Pointers, table pointers, converter control and watchdog select
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ptr0_q <= `DBS_BYTE_RST;
      ptr1_q <= `DBS_BYTE_RST;
      ptr2_q <= `DBS_BYTE_RST;
      dacc_q <= `DBS_BYTE_RST;
      tblp_q <= `DBS_BYTE_RST;
      tbmp_q <= `DBS_BYTE_RST;
      tbhp_q <= `DBS_BYTE_RST;
      watchdog_divider_select_q <= `DBS_WDT_SEL_RST;
    end else if (i_ce) begin
      if (sfr_we(`DBS_ADDR_BANK0_PTR, eff_addr, wr_ok, is_sfr)) ptr0_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_PTR_FIRST, eff_addr, wr_ok, is_sfr)) ptr1_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_PTR_SECOND, eff_addr, wr_ok, is_sfr)) ptr2_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_DAC_CTRL, eff_addr, wr_ok, is_sfr)) dacc_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_TBL_LOW, eff_addr, wr_ok, is_sfr)) tblp_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_TBL_MID, eff_addr, wr_ok, is_sfr)) tbmp_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_TBL_HIGH, eff_addr, wr_ok, is_sfr)) tbhp_q <= i_req.wdata;
      if (sfr_we(`DBS_ADDR_WDT_SEL, eff_addr, wr_ok, is_sfr)) begin
        watchdog_divider_select_q <= i_req.wdata & `DBS_WDT_SEL_MASK;
      end
    end
  end

  // Accumulator: ALU results land here
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= `DBS_BYTE_RST;
    end else if (i_ce) begin
      if (i_alu_wr_acc && !idle_q) begin
        acc_q <= i_alu_result;
      end else if (sfr_we(`DBS_ADDR_ACC, eff_addr, wr_ok, is_sfr)) begin
        acc_q <= i_req.wdata;
      end
    end
  end

  // ==========================================
  // Program-counter low: load pulse plus one idle cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pcl_q <= `DBS_BYTE_RST;
      o_pcl_load <= 1'b0;
      ex_q <= DBS_EX_RUN;
      idle_q <= 1'b0;
    end else if (i_ce) begin
      o_pcl_load <= 1'b0;
      unique case (ex_q)
        DBS_EX_RUN: begin
          if (sfr_we(`DBS_ADDR_PCL, eff_addr, wr_ok, is_sfr)) begin
            pcl_q <= i_req.wdata;
            o_pcl_load <= 1'b1;
            ex_q <= DBS_EX_IDLE;
            idle_q <= 1'b1;
          end
        end
        DBS_EX_IDLE: begin
          ex_q <= DBS_EX_RUN;
          idle_q <= 1'b0;
        end
        default: begin
          ex_q <= DBS_EX_RUN;
          idle_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Table read: high byte latched, low byte forwarded
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      table_high_latch_q <= `DBS_BYTE_RST;
      o_tbl_low <= 8'h00;
      o_tbl_low_valid <= 1'b0;
    end else if (i_ce) begin
      o_tbl_low_valid <= i_tbl_done;
      if (i_tbl_done) begin
        table_high_latch_q <= i_tbl_word[15:8];
        o_tbl_low <= i_tbl_word[7:0];
      end
    end
  end

  // ==========================================
  // Arithmetic flags: ALU update beats software write
  always_comb begin
    fl_c = c_q;
    fl_ac = ac_q;
    fl_z = z_q;
    fl_ov = ov_q;
    if (sfr_we(`DBS_ADDR_STATUS, eff_addr, wr_ok, is_sfr)) begin
      fl_c = i_req.wdata[`DBS_ST_C];
      fl_ac = i_req.wdata[`DBS_ST_AC];
      fl_z = i_req.wdata[`DBS_ST_Z];
      fl_ov = i_req.wdata[`DBS_ST_OV];
    end
    if (i_flags.upd_arith) begin
      fl_c = i_flags.c;
      fl_ac = i_flags.ac;
      fl_z = i_flags.z;
      fl_ov = i_flags.ov;
    end else if (i_flags.upd_c_only) begin
      fl_c = i_flags.c;
    end
  end

  // Flag registers; status is never stacked here
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      c_q <= 1'b0;
      ac_q <= 1'b0;
      z_q <= 1'b0;
      ov_q <= 1'b0;
    end else if (i_ce) begin
      c_q <= fl_c;
      ac_q <= fl_ac;
      z_q <= fl_z;
      ov_q <= fl_ov;
    end
  end

  // System flags: set beats clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pdf_q <= 1'b0;
      to_q <= 1'b0;
      sleep_q <= 1'b0;
    end else if (i_ce) begin
      if (i_sleep_op) begin
        pdf_q <= 1'b1;
      end else if (i_power_up || i_kick_op) begin
        pdf_q <= 1'b0;
      end
      if (wdt_to) begin
        to_q <= 1'b1;
      end else if (i_power_up || i_kick_op || i_sleep_op) begin
        to_q <= 1'b0;
      end
      if (i_sleep_op) begin
        sleep_q <= 1'b1;
      end else if (i_power_up || wdt_to) begin
        sleep_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_reset <= 1'b0;
      o_stall <= 1'b0;
    end else if (i_ce) begin
      o_wdt_reset <= wdt_to;
      o_stall <= sfr_we(`DBS_ADDR_PCL, eff_addr, wr_ok, is_sfr) && !idle_q;
    end
  end

  assign o_acc = acc_q;
  assign o_pcl_value = pcl_q;
  assign o_tbl_addr = {tbhp_q, tbmp_q, tblp_q};
  assign o_status = {2'h0, to_q, pdf_q, ov_q, z_q, ac_q, c_q};
  assign o_sleeping = sleep_q;

  // ==========================================
  // Watchdog
  dbs_watchdog u_wdt (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_kick(i_kick_op || i_power_up),
    .i_div_sel(watchdog_divider_select_q[2:0]),
    .o_timeout(wdt_to)
  );
endmodule : dbs_core_regs

// ===== sim/dbs_ram_model.sv
`timescale 1ns/1ps
// ==========================================
// General RAM behind the core registers
module dbs_ram_model
  import dbs_pkg::*;
(
  input wire logic i_clk_sys,
  input dbs_pkg::dbs_ram_req_type i_ram,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:2047];
  logic [7:0] last_q;
  // Write port; eleven-bit bank-and-offset address
  always @(posedge i_clk_sys) begin
    if (i_ram.wr) begin
      mem[i_ram.addr] <= i_ram.wdata;
    end
  end
  // Read data only while read; otherwise inverted last value
  always_comb begin
    o_rdata = i_ram.rd ? mem[i_ram.addr] : ~last_q;
  end
  // Last value driven, for the released-bus pattern
  always @(posedge i_clk_sys) begin
    last_q <= o_rdata;
  end
endmodule : dbs_ram_model

// ===== sim/dbs_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the core registers
module dbs_checker
  import dbs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_power_up,
  input wire logic i_sleep_op,
  input wire logic i_kick_op,
  input wire logic i_indirect,
  input dbs_pkg::dbs_mem_req_type i_req,
  input dbs_pkg::dbs_flag_upd_type i_flags,
  input wire logic i_tbl_done,
  input wire logic [15:0] i_tbl_word,
  input dbs_pkg::dbs_ram_req_type o_ram,
  input wire logic o_pcl_load,
  input wire logic [7:0] o_pcl_value,
  input wire logic o_stall,
  input wire logic [7:0] o_tbl_low,
  input wire logic o_tbl_low_valid,
  input wire logic [7:0] o_status,
  input wire logic o_sleeping
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Direct request that the core may accept
  wire logic dir_ok = i_ce && !i_indirect && !o_stall && !o_sleeping;
  wire logic no_sys = !i_sleep_op && !i_kick_op && !i_power_up;
  wire logic no_alu = !i_flags.upd_arith && !i_flags.upd_c_only;
  // ==========================================
  // Properties
  property p_pcl_jump;
    dir_ok && i_req.wr && i_req.addr == 8'h06 |=> o_pcl_load && o_pcl_value == $past(i_req.wdata);
  endproperty
  a_pcl_jump: assert property (p_pcl_jump) else $error("pcl jump wrong");
  property p_stall;
    o_pcl_load |-> o_stall ##1 !o_pcl_load;
  endproperty
  a_stall: assert property (p_stall) else $error("no idle cycle");
  property p_direct;
    dir_ok && i_req.wr && i_req.addr >= 8'h60
      |=> o_ram.wr && o_ram.addr == {3'b000, $past(i_req.addr)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct not bank zero");
  property p_sfr;
    dir_ok && (i_req.rd || i_req.wr) && i_req.addr < 8'h60 |=> !o_ram.rd && !o_ram.wr;
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr reached ram");
  property p_unbanked;
    i_ce && i_indirect && i_req.rd && i_req.addr == 8'h00 |=> o_ram.addr[10:8] == 3'b000;
  endproperty
  a_unbanked: assert property (p_unbanked) else $error("unbanked not bank zero");
  property p_status;
    dir_ok && i_req.wr && i_req.addr == 8'h0a && no_sys && no_alu
      |=> o_status[5:4] == $past(o_status[5:4]) && o_status[3:0] == $past(i_req.wdata[3:0]);
  endproperty
  a_status: assert property (p_status) else $error("status write wrong");
  property p_sleep;
    i_ce && i_sleep_op |=> o_status[4] && !o_status[5] && o_sleeping;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_kick;
    i_ce && i_kick_op && !i_sleep_op |=> o_status[5:4] == 2'b00;
  endproperty
  a_kick: assert property (p_kick) else $error("kick flags wrong");
  property p_flags;
    i_ce && i_flags.upd_arith |=> o_status[3:0] ==
      {$past(i_flags.ov), $past(i_flags.z), $past(i_flags.ac), $past(i_flags.c)};
  endproperty
  a_flags: assert property (p_flags) else $error("alu flags wrong");
  property p_tbl;
    i_ce && i_tbl_done |=> o_tbl_low_valid && o_tbl_low == $past(i_tbl_word[7:0]);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table low wrong");
endmodule : dbs_checker
bind dbs_core_regs dbs_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
  .i_power_up(i_power_up), .i_sleep_op(i_sleep_op), .i_kick_op(i_kick_op),
  .i_indirect(i_indirect), .i_req(i_req), .i_flags(i_flags), .i_tbl_done(i_tbl_done),
  .i_tbl_word(i_tbl_word), .o_ram(o_ram), .o_pcl_load(o_pcl_load), .o_pcl_value(o_pcl_value),
  .o_stall(o_stall), .o_tbl_low(o_tbl_low), .o_tbl_low_valid(o_tbl_low_valid),
  .o_status(o_status), .o_sleeping(o_sleeping));

// ===== sim/data_bank_select_and_core_flags_tb.sv
`timescale 1ns/1ps
module data_bank_select_and_core_flags_tb;
  import dbs_pkg::*;
  logic clk = 0, rst = 1, ce = 1, pu = 0, slp = 0, kick = 0, ind = 0, tdone = 0, awr = 0;
  logic [15:0] tword = '0;
  logic [7:0] ares = '0, ram_rd, rdata, acc, pclv, tlow, status;
  dbs_mem_req_type req = '0;
  dbs_flag_upd_type flg = '0;
  dbs_ram_req_type ram;
  logic pcl_load, stall, tvalid, wdt_rst, sleeping;
  logic [23:0] taddr;
  int miscompares = 0, compares = 0;
  // ==========================================
  // Clock, design and RAM
  always #20 clk = ~clk;
  dbs_core_regs dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_power_up(pu),
    .i_sleep_op(slp), .i_kick_op(kick), .i_indirect(ind), .i_req(req), .i_ram_rdata(ram_rd),
    .i_flags(flg), .i_tbl_done(tdone), .i_tbl_word(tword), .i_alu_result(ares),
    .i_alu_wr_acc(awr), .o_ram(ram), .o_rdata(rdata), .o_acc(acc), .o_pcl_load(pcl_load),
    .o_pcl_value(pclv), .o_stall(stall), .o_tbl_addr(taddr), .o_tbl_low(tlow),
    .o_tbl_low_valid(tvalid), .o_wdt_reset(wdt_rst), .o_status(status), .o_sleeping(sleeping));
  dbs_ram_model u_ram (.i_clk_sys(clk), .i_ram(ram), .o_rdata(ram_rd));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic op(input logic r, input logic w, input logic x, input logic [7:0] a,
                    input logic [7:0] d);
    @(negedge clk);
    ind = x;
    req = '{rd: r, wr: w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    ind = 0;
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(0, 1, 0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    op(1, 0, 0, a, 8'h00);
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse
  // ==========================================
  // Scenarios
  task automatic t_bank;
    wr(8'h04, 8'hfd);
    rd(8'h04);
    chk(8'h1d, rdata);
    wr(8'h03, 8'h70);
    wr(8'h1f, 8'h00);
    op(1, 0, 1, 8'h02, 8'h00);
    chk({3'd5, 8'h70}, ram.addr);
    wr(8'h2f, 8'h03);
    wr(8'h2e, 8'h81);
    wr(8'h1f, 8'h80);
    op(0, 1, 1, 8'h02, 8'h99);
    chk({1'b1, 3'd3, 8'h81, 8'h99}, {ram.wr, ram.addr, ram.wdata});
    wr(8'h01, 8'h65);
    op(1, 0, 1, 8'h00, 8'h00);
    chk(11'h065, ram.addr);
    wr(8'h60, 8'h5a);
    chk(11'h060, ram.addr);
    rd(8'h60);
    @(negedge clk);
    chk(8'h5a, rdata);
  endtask : t_bank
  task automatic t_window;
    wr(8'h1f, 8'h00);
    wr(8'h03, 8'h02);
    op(1, 0, 1, 8'h02, 8'h00);
    chk(8'h00, rdata);
    rd(8'h0f);
    chk(8'h00, rdata);
  endtask : t_window
  task automatic t_reset_bank;
    wr(8'h04, 8'h1f);
    pulse(pu);
    rd(8'h04);
    chk(8'h00, rdata);
  endtask : t_reset_bank
  task automatic t_acc;
    wr(8'h05, 8'h3c);
    chk(8'h3c, acc);
    ares = 8'hc3;
    pulse(awr);
    chk(8'hc3, acc);
    // Clock enable low freezes the accumulator
    @(negedge clk);
    ce = 0;
    ares = 8'h11;
    awr = 1;
    @(negedge clk);
    ce = 1;
    awr = 0;
    chk(8'hc3, acc);
  endtask : t_acc
  task automatic t_pcl;
    @(negedge clk);
    req = '{rd: 0, wr: 1, addr: 8'h06, wdata: 8'h44};
    @(negedge clk);
    req = '{rd: 0, wr: 1, addr: 8'h05, wdata: 8'h77};
    chk({pcl_load, stall, pclv}, {2'b11, 8'h44});
    @(negedge clk);
    req = '0;
    chk(8'hc3, acc);
    repeat (2) @(negedge clk);
  endtask : t_pcl
  task automatic t_table;
    wr(8'h07, 8'h12);
    wr(8'h2b, 8'h34);
    wr(8'h2c, 8'h56);
    chk(24'h563412, taddr);
    tword = 16'habcd;
    pulse(tdone);
    chk({tvalid, tlow}, 9'h1cd);
    rd(8'h08);
    chk(8'hab, rdata);
  endtask : t_table
  task automatic t_flags;
    wr(8'h0a, 8'hff);
    chk(8'h0f, status);
    @(negedge clk);
    flg = '{upd_arith: 1, upd_c_only: 0, c: 0, ac: 1, z: 0, ov: 0};
    @(negedge clk);
    flg = '{upd_arith: 0, upd_c_only: 1, c: 1, ac: 0, z: 1, ov: 1};
    @(negedge clk);
    flg = '0;
    chk(8'h03, status);
  endtask : t_flags
  task automatic t_wdt;
    logic seen;
    seen = 0;
    pulse(kick);
    wr(8'h04, 8'h0b);
    wr(8'h09, 8'h00);
    for (int i = 0; i < 1000 && !seen; i++) begin
      @(negedge clk);
      seen = wdt_rst;
    end
    chk(1'b1, seen);
    chk(1'b1, status[5]);
    rd(8'h04);
    chk(8'h00, rdata);
    pulse(kick);
    chk(2'b00, status[5:4]);
    wr(8'h09, 8'h07);
  endtask : t_wdt
  task automatic t_sleep;
    logic seen;
    seen = 0;
    wr(8'h04, 8'h0a);
    wr(8'h09, 8'h00);
    pulse(kick);
    pulse(slp);
    chk({sleeping, status[5:4]}, 3'b101);
    // Time-out while asleep wakes the core and keeps the bank
    for (int i = 0; i < 1000 && !seen; i++) begin
      @(negedge clk);
      seen = wdt_rst;
    end
    chk({seen, sleeping, status[5]}, 3'b101);
    rd(8'h04);
    chk(8'h0a, rdata);
  endtask : t_sleep
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_bank();
    t_window();
    t_reset_bank();
    t_acc();
    t_pcl();
    t_table();
    t_flags();
    t_wdt();
    t_sleep();
    tally_and_finish();
  end
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule : data_bank_select_and_core_flags_tb
